// ===== hw/fas_pkg.sv
// Constants and types shared by the fetch and absolute address sequencer
package fas_pkg;

   // ***************************************************************
   // Bus widths and address space
   // ***************************************************************
   localparam int ADDR_WIDTH = 16;
   localparam int DATA_WIDTH = 8;
   localparam logic [7:0] ZERO_PAGE = 8'h00;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] PC_STEP = 16'h0001;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // ***************************************************************
   // Memory cycle slots and timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 40;
   localparam int PHASE_MIN_NS = 80;
   localparam int PHASE_SLOTS = (PHASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SLOT_WIDTH = 3;
   localparam logic [2:0] SLOT_FIRST = 3'h0;
   localparam logic [2:0] SLOT_PHI1_LAST = SLOT_FIRST + 3'(PHASE_SLOTS - 1);
   localparam logic [2:0] SLOT_GAP_ONE = SLOT_PHI1_LAST + 3'h1;
   localparam logic [2:0] SLOT_PHI2_FIRST = SLOT_GAP_ONE + 3'h1;
   localparam logic [2:0] SLOT_PHI2_LAST = SLOT_PHI2_FIRST + 3'(PHASE_SLOTS - 1);
   localparam logic [2:0] SLOT_LAST = SLOT_PHI2_LAST + 3'h1;

   // ***************************************************************
   // Opcode fields
   // ***************************************************************
   localparam int OPC_MODE_LSB = 0;
   localparam int OPC_OP_LSB = 4;
   localparam logic [1:0] MODEF_IMPLIED = 2'h0;
   localparam logic [1:0] MODEF_IMMEDIATE = 2'h1;
   localparam logic [1:0] MODEF_ZERO_PAGE = 2'h2;
   localparam logic [1:0] MODEF_ABSOLUTE = 2'h3;
   localparam logic [3:0] OPF_LOAD = 4'h1;
   localparam logic [3:0] OPF_STORE = 4'h2;
   localparam logic [3:0] OPF_ADD = 4'h3;
   localparam logic [3:0] OPF_TRANSFER = 4'h4;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {MODE_IMPLIED, MODE_IMMEDIATE, MODE_ZERO_PAGE, MODE_ABSOLUTE}
      fasMode_type;
   typedef enum logic [2:0] {OP_NONE, OP_LOAD, OP_STORE, OP_ADD, OP_TRANSFER} fasOp_type;
   typedef enum logic [1:0] {ST_OPCODE, ST_SECOND, ST_ADDR_HIGH, ST_OPERAND} fasState_type;

   typedef struct packed {
      fasOp_type op;
      fasMode_type mode;
      logic [1:0] instrBytes;
   } fasDecode_type;

   typedef struct packed {
      logic [ADDR_WIDTH-1:0] addr;
      logic readNotWrite;
      logic [DATA_WIDTH-1:0] writeData;
      logic writeOe;
   } fasBus_type;

   typedef struct packed {
      logic phaseOne;
      logic phaseTwo;
   } fasPhase_type;

   localparam fasDecode_type DECODE_RESET = '{op: OP_NONE, mode: MODE_IMPLIED,
      instrBytes: 2'h1};
   localparam fasBus_type BUS_RESET = '{addr: PC_RESET, readNotWrite: 1'b1,
      writeData: BYTE_RESET, writeOe: 1'b0};
   localparam fasPhase_type PHASE_RESET = '{phaseOne: 1'b1, phaseTwo: 1'b0};

endpackage

// ===== hw/fas_phase_gen.sv
// Two non-overlapping phase clocks and the slot counter of one memory cycle
`timescale 1ns/1ps
`default_nettype none
module fas_phase_gen (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Phase outputs
   output fas_pkg::fasPhase_type phase,
   output logic [fas_pkg::SLOT_WIDTH-1:0] slot
);
   import fas_pkg::*;

   logic [SLOT_WIDTH-1:0] next_slot;

   always_comb begin
      if (slot == SLOT_LAST) begin
         next_slot = SLOT_FIRST;
      end else begin
         next_slot = slot + 3'h1;
      end
   end

   // Gap slots between the phases keep them from ever overlapping
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         slot <= SLOT_FIRST;
         phase <= PHASE_RESET;
      end else begin
         slot <= next_slot;
         phase.phaseOne <= (next_slot <= SLOT_PHI1_LAST);
         phase.phaseTwo <= (next_slot >= SLOT_PHI2_FIRST) && (next_slot <= SLOT_PHI2_LAST);
      end
   end

   AST_PHASE_NONOVERLAP: assert property (@(posedge clk_sys) disable iff (rst)
      !(phase.phaseOne && phase.phaseTwo))
      else $error("phase clocks overlap");

   AST_PHASE_ORDER: assert property (@(posedge clk_sys) disable iff (rst)
      (slot == SLOT_LAST) |=> phase.phaseOne ##(PHASE_SLOTS + 1) phase.phaseTwo)
      else $error("phase clocks out of order");

endmodule
`default_nettype wire

// ===== hw/fas_opcode_decode.sv
// Opcode decoder holding the class and length of the current instruction
`timescale 1ns/1ps
`default_nettype none
module fas_opcode_decode (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Opcode in
   input wire logic load,
   input wire logic [7:0] opcode,
   // Decoded class
   output fas_pkg::fasDecode_type decode
);
   import fas_pkg::*;

   fasDecode_type next_decode;

   always_comb begin
      next_decode = DECODE_RESET;
      unique case (opcode[OPC_MODE_LSB +: 2])
         MODEF_IMPLIED: begin
            next_decode.mode = MODE_IMPLIED;
            next_decode.instrBytes = 2'h1;
         end
         MODEF_IMMEDIATE: begin
            next_decode.mode = MODE_IMMEDIATE;
            next_decode.instrBytes = 2'h2;
         end
         MODEF_ZERO_PAGE: begin
            next_decode.mode = MODE_ZERO_PAGE;
            next_decode.instrBytes = 2'h2;
         end
         MODEF_ABSOLUTE: begin
            next_decode.mode = MODE_ABSOLUTE;
            next_decode.instrBytes = 2'h3;
         end
      endcase
      case (opcode[OPC_OP_LSB +: 4])
         OPF_LOAD: next_decode.op = (next_decode.mode == MODE_IMPLIED) ? OP_NONE : OP_LOAD;
         OPF_ADD: next_decode.op = (next_decode.mode == MODE_IMPLIED) ? OP_NONE : OP_ADD;
         // A store of an immediate byte has nowhere to go
         OPF_STORE: begin
            if (next_decode.mode == MODE_ZERO_PAGE || next_decode.mode == MODE_ABSOLUTE) begin
               next_decode.op = OP_STORE;
            end else begin
               next_decode.op = OP_NONE;
            end
         end
         OPF_TRANSFER: begin
            next_decode.op = (next_decode.mode == MODE_IMPLIED) ? OP_TRANSFER : OP_NONE;
         end
         default: next_decode.op = OP_NONE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         decode <= DECODE_RESET;
      end else if (load) begin
         decode <= next_decode;
      end
   end

   AST_DECODE_LENGTH: assert property (@(posedge clk_sys) disable iff (rst)
      load |=> (decode.instrBytes >= 2'h1) && (decode.instrBytes == 2'h1) ==
         (decode.mode == MODE_IMPLIED))
      else $error("instruction length does not match its mode");

endmodule
`default_nettype wire

// ===== hw/fas_sequencer.sv
// Instruction fetch and operand address sequencer, top level
//
// Contract
// - Every access uses a 16-bit address; 65,536 byte locations of 8 bits.
// - Address space is 256 pages of 256 bytes; high byte is the page.
// - Instructions are one opcode byte plus zero, one or two address bytes.
// - Implied instructions finish from the opcode alone; the next byte is read but the counter holds.
// - Absolute mode reads opcode, low byte, high byte at successive locations.
// - Cycle 4 drives high byte and low byte together and moves the operand.
// - Counter steps as each opcode is fetched; new value addresses the next cycle.
// - Byte fetches overlap decoding: two bytes two cycles, three bytes three.
// - Every cycle is exactly one read or one write; memory always answers.
// - A cycle is one full pass of each of two non-overlapping phases.
// - Each instruction takes at least two cycles; cycles match memory accesses.
// - Next opcode is fetched while arithmetic completes; result lands cycle after.
`timescale 1ns/1ps
`default_nettype none
module fas_sequencer (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Memory bus
   output fas_pkg::fasBus_type bus,
   input wire logic [fas_pkg::DATA_WIDTH-1:0] memReadData,
   // Phase clocks
   output fas_pkg::fasPhase_type phase,
   // Processor status
   output logic opcodeFetch,
   output logic [fas_pkg::DATA_WIDTH-1:0] accumulator,
   output logic [fas_pkg::DATA_WIDTH-1:0] indexX
);
   import fas_pkg::*;

   // ***************************************************************
   // Declarations
   // ***************************************************************
   logic [SLOT_WIDTH-1:0] slot;
   logic cycleEnd;
   logic [DATA_WIDTH-1:0] dataMeta;
   logic [DATA_WIDTH-1:0] dataSync2;
   logic [DATA_WIDTH-1:0] dataSync3;
   logic [DATA_WIDTH-1:0] dataStable;
   fasState_type state;
   fasState_type next_state;
   logic [ADDR_WIDTH-1:0] pc;
   logic [ADDR_WIDTH-1:0] next_pc;
   logic [ADDR_WIDTH-1:0] next_addr;
   logic next_store;
   logic opcodeLoad;
   fasDecode_type decode;
   logic [7:0] addrLow;
   logic execPending;
   fasOp_type execOp;
   logic [DATA_WIDTH-1:0] operandReg;
   logic [DATA_WIDTH-1:0] aluResult;
   logic resultPending;
   logic carryFlag;
   logic [DATA_WIDTH:0] sum;
   logic [DATA_WIDTH-1:0] accForward;
   logic operandByte;
   logic [2:0] instrCycles;

   // ***************************************************************
   // Phase clocks and memory cycle framing
   // ***************************************************************
   fas_phase_gen phaseGen (
      .clk_sys(clk_sys),
      .rst(rst),
      .phase(phase),
      .slot(slot)
   );

   // Sequence state, counter and bus address move once per memory cycle, at its last slot
   assign cycleEnd = (slot == SLOT_LAST);

   // ***************************************************************
   // Read data synchroniser
   // ***************************************************************
   // Memory answers from outside our clock; a byte is taken only once
   // two stages agree, so a bus still settling is never consumed
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dataMeta <= BYTE_RESET;
         dataSync2 <= BYTE_RESET;
         dataSync3 <= BYTE_RESET;
      end else begin
         dataMeta <= memReadData;
         dataSync2 <= dataMeta;
         dataSync3 <= dataSync2;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dataStable <= BYTE_RESET;
      end else if (dataSync2 == dataSync3) begin
         dataStable <= dataSync3;
      end
   end

   // ***************************************************************
   // Opcode decode
   // ***************************************************************
   assign opcodeLoad = cycleEnd && (state == ST_OPCODE);

   fas_opcode_decode opcodeDecode (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(opcodeLoad),
      .opcode(dataStable),
      .decode(decode)
   );

   // ***************************************************************
   // Fetch sequence
   // ***************************************************************
   always_comb begin
      next_state = state;
      next_pc = pc;
      unique case (state)
         ST_OPCODE: begin
            next_state = ST_SECOND;
            next_pc = pc + PC_STEP;
         end
         ST_SECOND: begin
            // The byte after the opcode is always read while decoding runs
            unique case (decode.mode)
               MODE_IMPLIED: begin
                  next_state = ST_OPCODE;
               end
               MODE_IMMEDIATE: begin
                  next_state = ST_OPCODE;
                  next_pc = pc + PC_STEP;
               end
               MODE_ZERO_PAGE: begin
                  next_state = ST_OPERAND;
                  next_pc = pc + PC_STEP;
               end
               MODE_ABSOLUTE: begin
                  next_state = ST_ADDR_HIGH;
                  next_pc = pc + PC_STEP;
               end
            endcase
         end
         ST_ADDR_HIGH: begin
            next_state = ST_OPERAND;
            next_pc = pc + PC_STEP;
         end
         ST_OPERAND: begin
            next_state = ST_OPCODE;
         end
      endcase
   end

   always_comb begin
      next_addr = next_pc;
      if (next_state == ST_OPERAND) begin
         if (state == ST_ADDR_HIGH) begin
            next_addr = {dataStable, addrLow};
         end else begin
            next_addr = {ZERO_PAGE, dataStable};
         end
      end
      next_store = (next_state == ST_OPERAND) && (decode.op == OP_STORE);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= ST_OPCODE;
         pc <= PC_RESET;
      end else if (cycleEnd) begin
         state <= next_state;
         pc <= next_pc;
      end
   end

   // ***************************************************************
   // Address bytes
   // ***************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         addrLow <= BYTE_RESET;
      end else if (cycleEnd) begin
         // The high byte goes straight onto the bus, so only the low one is held
         if (state == ST_SECOND && (decode.mode == MODE_ZERO_PAGE ||
               decode.mode == MODE_ABSOLUTE)) begin
            addrLow <= dataStable;
         end
      end
   end

   // ***************************************************************
   // Memory bus drive
   // ***************************************************************
   // Reduced packages simply leave the upper address lines unbonded
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bus <= BUS_RESET;
      end else begin
         if (cycleEnd) begin
            bus.addr <= next_addr;
            bus.readNotWrite <= !next_store;
            bus.writeData <= accForward;
         end
         // Data is driven only while the second phase is high
         bus.writeOe <= !bus.readNotWrite && !cycleEnd &&
            (slot == SLOT_GAP_ONE || slot == SLOT_PHI2_FIRST);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         opcodeFetch <= 1'b1;
      end else if (cycleEnd) begin
         opcodeFetch <= (next_state == ST_OPCODE);
      end
   end

   // ***************************************************************
   // Execution overlap
   // ***************************************************************
   assign sum = {1'b0, accumulator} + {1'b0, operandReg} + {8'h00, carryFlag};
   // A result still in flight is forwarded so a transfer right behind sees it
   assign accForward = resultPending ? aluResult : accumulator;
   assign operandByte = (decode.op == OP_LOAD) || (decode.op == OP_ADD);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         execPending <= 1'b0;
         execOp <= OP_NONE;
         operandReg <= BYTE_RESET;
         aluResult <= BYTE_RESET;
         resultPending <= 1'b0;
         carryFlag <= 1'b0;
         accumulator <= BYTE_RESET;
         indexX <= BYTE_RESET;
      end else if (cycleEnd) begin
         unique case (state)
            ST_OPCODE: begin
               if (execPending) begin
                  execPending <= 1'b0;
                  resultPending <= 1'b1;
                  if (execOp == OP_ADD) begin
                     aluResult <= sum[DATA_WIDTH-1:0];
                     carryFlag <= sum[DATA_WIDTH];
                  end else begin
                     aluResult <= operandReg;
                  end
               end
            end
            ST_SECOND: begin
               if (resultPending) begin
                  accumulator <= aluResult;
                  resultPending <= 1'b0;
               end
               if (decode.mode == MODE_IMPLIED && decode.op == OP_TRANSFER) begin
                  indexX <= accForward;
               end
               if (decode.mode == MODE_IMMEDIATE && operandByte) begin
                  operandReg <= dataStable;
                  execOp <= decode.op;
                  execPending <= 1'b1;
               end
            end
            ST_ADDR_HIGH: begin
            end
            ST_OPERAND: begin
               if (operandByte) begin
                  operandReg <= dataStable;
                  execOp <= decode.op;
                  execPending <= 1'b1;
               end
            end
         endcase
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         instrCycles <= 3'h0;
      end else if (cycleEnd) begin
         instrCycles <= (state == ST_OPCODE) ? 3'h1 : instrCycles + 3'h1;
      end
   end

   AST_PC_STEP: assert property (@(posedge clk_sys) disable iff (rst)
      opcodeLoad |=> (pc == $past(pc) + PC_STEP) && (bus.addr == pc))
      else $error("counter did not step onto the bus after opcode fetch");

   AST_TWO_CYCLES: assert property (@(posedge clk_sys) disable iff (rst)
      opcodeLoad |=> (state == ST_SECOND) [*6])
      else $error("instruction shorter than two cycles");

   AST_IMPLIED_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      cycleEnd && state == ST_SECOND && decode.mode == MODE_IMPLIED
         |=> state == ST_OPCODE && $stable(pc))
      else $error("implied instruction fetched another byte");

   AST_ABS_ADDR: assert property (@(posedge clk_sys) disable iff (rst)
      cycleEnd && state == ST_ADDR_HIGH |=> bus.addr == {$past(dataStable), addrLow}
         && state == ST_OPERAND)
      else $error("operand address not formed from high and low bytes");

   AST_LOW_HELD: assert property (@(posedge clk_sys) disable iff (rst)
      state == ST_ADDR_HIGH && !cycleEnd |=> $stable(addrLow))
      else $error("low address byte lost during high byte fetch");

   AST_ZERO_PAGE: assert property (@(posedge clk_sys) disable iff (rst)
      state == ST_OPERAND && decode.mode == MODE_ZERO_PAGE |-> bus.addr[15:8] == ZERO_PAGE)
      else $error("zero page access left page zero");

   AST_ABS_CYCLE: assert property (@(posedge clk_sys) disable iff (rst)
      state == ST_ADDR_HIGH |-> instrCycles == 3'h2 && decode.instrBytes == 2'h3)
      else $error("absolute high byte not fetched in cycle three");

   AST_MAX_LENGTH: assert property (@(posedge clk_sys) disable iff (rst)
      instrCycles <= 3'h4)
      else $error("instruction ran over four cycles");

   AST_ONE_ACCESS: assert property (@(posedge clk_sys) disable iff (rst)
      bus.writeOe |-> !bus.readNotWrite && phase.phaseTwo)
      else $error("write data driven outside a write cycle");

   AST_ADDR_STABLE: assert property (@(posedge clk_sys) disable iff (rst)
      !cycleEnd |=> $stable(bus.addr) && $stable(bus.readNotWrite))
      else $error("address changed inside a memory cycle");

   AST_WRITEBACK: assert property (@(posedge clk_sys) disable iff (rst)
      opcodeLoad && execPending |=> resultPending ##6 accumulator == $past(aluResult, 6)
         && !resultPending)
      else $error("result not written the cycle after the next opcode");

endmodule
`default_nettype wire

// ===== tb/fas_memory_model.sv
// Byte memory standing on the far side of the sequencer's bus
`timescale 1ns/1ps
`default_nettype none
module fas_memory_model (
   // Clock
   input wire logic clk_sys,
   // Bus from the sequencer
   input wire fas_pkg::fasBus_type bus,
   input wire logic slow,
   // Read data back
   output logic [7:0] memReadData
);
   import fas_pkg::*;
   logic [7:0] mem [0:65535];
   logic [15:0] seen;
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      seen = 16'h0000;
   end
   // Address of the previous clock; a slow part is wrong for one clock
   always @(posedge clk_sys) begin
      seen <= bus.addr;
      if (bus.writeOe && !bus.readNotWrite) begin
         mem[bus.addr] <= bus.writeData;
      end
   end
   // Not driving during writes or while settling, so show the inverse
   always_comb begin
      if (!bus.readNotWrite || (slow && seen !== bus.addr)) begin
         memReadData = ~mem[bus.addr];
      end else begin
         memReadData = mem[bus.addr];
      end
   end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the fetch and absolute address sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import fas_pkg::*;
   typedef struct packed {
      logic [15:0] addr;
      logic rnw;
      logic fetch;
      logic [7:0] data;
   } fasNote_type;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic slow = 1'b0;
   fasBus_type bus;
   fasPhase_type phase;
   logic opcodeFetch;
   logic [7:0] memReadData;
   logic [7:0] accumulator;
   logic [7:0] indexX;
   fasNote_type notes[$];
   fasNote_type n;
   int err_count = 0;
   int checked = 0;
   int gap = -100;
   logic p2 = 1'b0;
   logic [15:0] a1, a2, a3;
   logic [7:0] v1, v3, v4, v5, zp;
   logic [7:0] prog [16];
   logic [15:0] addrs [21];

   fas_sequencer fas_sequencer_i (.clk_sys(clk_sys), .rst(rst), .bus(bus),
      .memReadData(memReadData), .phase(phase), .opcodeFetch(opcodeFetch),
      .accumulator(accumulator), .indexX(indexX));
   fas_memory_model fas_memory_model_i (.clk_sys(clk_sys), .bus(bus), .slow(slow),
      .memReadData(memReadData));

   always #20 clk_sys = ~clk_sys;

   // ***************************************************************
   // Compare and report
   // ***************************************************************
   task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_flag(input string what, input logic exp, input logic got);
      check_word(what, {15'h0000, exp}, {15'h0000, got});
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic note(input logic [15:0] a, input logic r, input logic f, input logic [7:0] d);
      notes.push_back('{a, r, f, d});
   endtask

   // One rising phase two per memory cycle marks one access
   always @(posedge clk_sys) begin
      #2;
      gap = rst ? -100 : gap + 1;
      if (phase.phaseTwo && !p2 && !rst) begin
         if (gap > 0) check_word("cycle length", 16'h0006, 16'(gap));
         gap = 0;
         check_flag("phase overlap", 1'b0, phase.phaseOne);
         check_flag("data enable", ~bus.readNotWrite, bus.writeOe);
         if (notes.size() > 0) begin
            n = notes.pop_front();
            check_word("address", n.addr, bus.addr);
            check_flag("read", n.rnw, bus.readNotWrite);
            check_flag("opcode fetch", n.fetch, opcodeFetch);
            if (!n.rnw) check_word("write data", {8'h00, n.data}, {8'h00, bus.writeData});
         end
      end
      p2 = phase.phaseTwo;
   end

   // ***************************************************************
   // Program runs, fast memory then slow memory after a fresh reset
   // ***************************************************************
   initial begin
      void'($urandom(32'h5d47));
      for (int run = 0; run < 2; run++) begin
         @(posedge clk_sys);
         #1 rst = 1'b1;
         slow = run[0];
         a1 = {8'h40 + 8'($urandom_range(63)), 8'($urandom)};
         a2 = {8'h80 + 8'($urandom_range(63)), 8'hFF};
         a3 = {8'hC0 + 8'($urandom_range(63)), 8'h00};
         zp = 8'h20 + 8'($urandom_range(200));
         v1 = 8'($urandom);
         v3 = 8'($urandom);
         v4 = 8'($urandom);
         v5 = 8'($urandom);
         prog = '{8'h13, a1[7:0], a1[15:8], 8'h40, 8'h23, a2[7:0], a2[15:8], 8'h11, v4,
            8'h12, zp, 8'h33, a3[7:0], a3[15:8], 8'h00, 8'h00};
         foreach (prog[i]) fas_memory_model_i.mem[16'(i)] = prog[i];
         fas_memory_model_i.mem[a1] = v1;
         fas_memory_model_i.mem[a2] = ~v1;
         fas_memory_model_i.mem[a3] = v3;
         fas_memory_model_i.mem[{8'h00, zp}] = v5;
         // Implied op rereads 0004 and the next opcode comes from there too
         addrs = '{16'h0000, 16'h0001, 16'h0002, a1, 16'h0003, 16'h0004, 16'h0004,
            16'h0005, 16'h0006, a2, 16'h0007, 16'h0008, 16'h0009, 16'h000A, {8'h00, zp},
            16'h000B, 16'h000C, 16'h000D, a3, 16'h000E, 16'h000F};
         foreach (addrs[i]) note(addrs[i], i != 9, i inside {0, 4, 6, 10, 12, 15, 19}, v1);
         repeat (4) @(posedge clk_sys);
         #1 rst = 1'b0;
         for (int k = 0; k < 400 && notes.size() > 0; k++) @(posedge clk_sys);
         if (notes.size() > 0) begin
            err_count++;
            break;
         end
         // Sum lands at the end of the cycle after the next opcode fetch
         repeat (6) @(posedge clk_sys);
         #2;
         check_word("accumulator", {8'h00, 8'(v5 + v3)}, {8'h00, accumulator});
         check_word("index", {8'h00, v1}, {8'h00, indexX});
         check_word("stored byte", {8'h00, v1}, {8'h00, fas_memory_model_i.mem[a2]});
         $display("run %0d finished slow %0d", run, slow);
      end
      stop_test();
   end
endmodule
`default_nettype wire
